// *** synth_vco_autoselect_ctrl.v ***
`timescale 1ns/10ps
`include "synth_ctrl_map.vh"

module synth_vco_autoselect_ctrl (
  input wire core_clk,
  input wire arst_n,
  input wire clk_en,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  input wire addr_select,
  input wire [2:0] oscillator_tune_pin,
  output reg [14:0] integer_divide,
  output reg [19:0] fraction_word,
  output reg [4:0] reference_ratio,
  output reg [7:0] pump_and_divide,
  output reg [4:0] oscillator_in_use,
  output reg standby_request,
  output reg search_running
);

  // ****************************************
  // Bus state encoding
  // ****************************************
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_DEV = 5'h02;
  localparam [4:0] ST_REG = 5'h04;
  localparam [4:0] ST_WR = 5'h08;
  localparam [4:0] ST_RD = 5'h10;

  // ****************************************
  // Input synchronisers
  // ****************************************
  reg scl_m, scl_s, scl_d;
  reg sda_m, sda_s, sda_d;
  reg addr_m, addr_s;
  reg [2:0] tune_m, tune_s;

  // Pins are asynchronous to core_clk; two stages before any use
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      addr_m <= 1'b0;
      addr_s <= 1'b0;
      tune_m <= `RST_CODE;
      tune_s <= `RST_CODE;
    end else if (clk_en) begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      addr_m <= addr_select;
      addr_s <= addr_m;
      tune_m <= oscillator_tune_pin;
      tune_s <= tune_m;
    end
  end

  // Bus events seen on the synchronised copies only
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;

  // ****************************************
  // Register storage
  // ****************************************
  reg [7:0] ctrl_reg, int_hi, int_lo, frac_hi, frac_mid, frac_lo;
  reg [7:0] ref_reg, pump_reg, osc_reg;
  reg [2:0] adc_latched;

  wire [4:0] manual_select = osc_reg[`OSC_SEL_HI:`OSC_SEL_LO];
  wire auto_search = osc_reg[`OSC_AUTO];
  wire adc_enable = osc_reg[`OSC_ADC_EN];

  // Search engine outputs
  wire srch_busy, srch_done, srch_success;
  wire [4:0] srch_index;

  // Status bytes as seen by a bus read
  wire [7:0] status1 = {srch_done, srch_success, srch_busy, 5'h00};
  wire [7:0] status2 = {oscillator_in_use, adc_latched};

  // Read-back selector, shared by first load and follow-on bytes
  function [7:0] read_byte;
    input [2:0] idx;
    input [7:0] s1;
    input [7:0] s2;
    begin
      case (idx)
        `RD_STATUS1: read_byte = s1;
        `RD_STATUS2: read_byte = s2;
        default: read_byte = `RST_BYTE;
      endcase
    end
  endfunction

  // ****************************************
  // 2-wire slave
  // ****************************************
  reg [4:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift_in;
  reg [7:0] shift_out;
  reg [7:0] reg_ptr;
  reg [2:0] rd_idx;
  reg rw_bit;
  reg master_ack, skip_fall;
  reg wr_stb;
  reg [7:0] wr_addr;
  reg [7:0] wr_data;

  wire [6:0] dev_addr = (`DEV_ADDR_BASE & `DEV_ADDR_MASK) | {6'h00, addr_s};
  wire [7:0] rd_next = read_byte(rd_idx, status1, status2);

  // SDA is open drain: data zero drives low, data one releases
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      bit_cnt <= `BIT_ZERO;
      shift_in <= `RST_BYTE;
      shift_out <= `RST_BYTE;
      reg_ptr <= `RST_BYTE;
      rd_idx <= `RD_STATUS1;
      rw_bit <= 1'b0;
      master_ack <= 1'b0;
      skip_fall <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
      wr_stb <= 1'b0;
      wr_addr <= `RST_BYTE;
      wr_data <= `RST_BYTE;
    end else if (clk_en) begin
      wr_stb <= 1'b0;
      if (bus_start) begin
        state <= ST_DEV;
        bit_cnt <= `BIT_ZERO;
        skip_fall <= 1'b1;
        sda_oe_n <= 1'b1;
      end else if (bus_stop) begin
        state <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
        if (bit_cnt == `BIT_ACK) begin
          master_ack <= ~sda_s;
        end else begin
          shift_in <= {shift_in[6:0], sda_s};
        end
      end else if (scl_fall && skip_fall) begin
        skip_fall <= 1'b0; // The START's own clock fall carries no bit
      end else if (scl_fall && state != ST_IDLE) begin
        if (bit_cnt == `BIT_LAST) begin
          bit_cnt <= `BIT_ACK;
          case (state)
            ST_DEV: begin
              if (shift_in[7:1] == dev_addr) begin
                rw_bit <= shift_in[0];
                sda_oe_n <= 1'b0;
              end else begin
                state <= ST_IDLE;
              end
            end
            ST_REG: begin
              reg_ptr <= shift_in;
              sda_oe_n <= 1'b0;
            end
            ST_WR: begin
              wr_stb <= 1'b1;
              wr_addr <= reg_ptr;
              wr_data <= shift_in;
              reg_ptr <= reg_ptr + `PTR_STEP;
              sda_oe_n <= 1'b0;
            end
            ST_RD: begin
              sda_oe_n <= 1'b1;
            end
            default: begin
              state <= ST_IDLE;
            end
          endcase
        end else if (bit_cnt == `BIT_ACK) begin
          bit_cnt <= `BIT_ZERO;
          sda_oe_n <= 1'b1;
          case (state)
            ST_DEV: begin
              if (rw_bit) begin
                state <= ST_RD;
                shift_out <= read_byte(`RD_STATUS1, status1, status2);
                sda_oe_n <= status1[`ST1_DONE]; // MSB goes out first
                rd_idx <= `RD_STATUS1 + `RIDX_STEP;
              end else begin
                state <= ST_REG;
              end
            end
            ST_REG: state <= ST_WR;
            ST_WR: state <= ST_WR;
            ST_RD: begin
              if (master_ack) begin
                shift_out <= rd_next;
                sda_oe_n <= rd_next[7];
                rd_idx <= rd_idx + `RIDX_STEP;
              end else begin
                state <= ST_IDLE;
              end
            end
            default: state <= ST_IDLE;
          endcase
        end else begin
          bit_cnt <= bit_cnt + `BIT_ONE;
          if (state == ST_RD) begin
            shift_out <= {shift_out[6:0], 1'b0};
            sda_oe_n <= shift_out[6];
          end
        end
      end
    end
  end

  // ****************************************
  // Register writes and their side effects
  // ****************************************
  reg search_kick;

  // Contents are never touched by standby, so they survive it
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= `RST_BYTE;
      int_hi <= `RST_BYTE;
      int_lo <= `RST_BYTE;
      frac_hi <= `RST_BYTE;
      frac_mid <= `RST_BYTE;
      frac_lo <= `RST_BYTE;
      ref_reg <= `RST_BYTE;
      pump_reg <= `RST_BYTE;
      osc_reg <= `RST_OSC_REG;
      adc_latched <= `RST_CODE;
      search_kick <= 1'b0;
    end else if (clk_en) begin
      search_kick <= 1'b0;
      if (wr_stb) begin
        case (wr_addr)
          `REG_CONTROL: ctrl_reg <= wr_data;
          `REG_INT_UPPER: int_hi <= wr_data;
          `REG_INT_LOWER: int_lo <= wr_data;
          `REG_FRAC_UPPER: frac_hi <= wr_data;
          `REG_FRAC_MIDDLE: frac_mid <= wr_data;
          `REG_FRAC_LOW: begin
            frac_lo <= wr_data;
            search_kick <= auto_search;
          end
          `REG_REF_DIV: ref_reg <= wr_data;
          `REG_PUMP_DIV: pump_reg <= wr_data;
          `REG_OSC: begin
            osc_reg <= wr_data;
            // Latch only a converter already running from an earlier enable
            if (wr_data[`OSC_ADC_LATCH] && adc_enable) begin
              adc_latched <= tune_s;
            end
          end
          default: ctrl_reg <= ctrl_reg;
        endcase
      end
    end
  end

  // ****************************************
  // Oscillator search engine
  // ****************************************
  // Standby stops the analogue loop, so the search is frozen with it
  osc_search u_search (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .run_en(clk_en & ~ctrl_reg[`CTRL_STANDBY]),
    .start(search_kick),
    .start_index(manual_select),
    .tune_code(tune_s),
    .busy(srch_busy),
    .done(srch_done),
    .success(srch_success),
    .index(srch_index)
  );

  // ****************************************
  // Registered outputs
  // ****************************************
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      integer_divide <= 15'h0000;
      fraction_word <= 20'h00000;
      reference_ratio <= 5'h00;
      pump_and_divide <= `RST_BYTE;
      oscillator_in_use <= `RST_IDX;
      standby_request <= 1'b0;
      search_running <= 1'b0;
    end else if (clk_en) begin
      integer_divide <= {int_hi[6:0], int_lo};
      fraction_word <= {frac_hi[3:0], frac_mid, frac_lo};
      reference_ratio <= ref_reg[4:0];
      pump_and_divide <= pump_reg;
      oscillator_in_use <= auto_search ? srch_index : manual_select;
      standby_request <= ctrl_reg[`CTRL_STANDBY];
      search_running <= srch_busy;
    end
  end

endmodule

// *** synth_ctrl_map.vh ***
`ifndef SYNTH_CTRL_MAP_VH
`define SYNTH_CTRL_MAP_VH

// Register offsets on the 2-wire bus
`define REG_CONTROL 8'h00
`define REG_INT_UPPER 8'h01
`define REG_INT_LOWER 8'h02
`define REG_FRAC_UPPER 8'h03
`define REG_FRAC_MIDDLE 8'h04
`define REG_FRAC_LOW 8'h05
`define REG_REF_DIV 8'h06
`define REG_PUMP_DIV 8'h07
`define REG_OSC 8'h08

// Read-back index order
`define RD_STATUS1 3'h0
`define RD_STATUS2 3'h1

// Field positions
`define CTRL_STANDBY 7
`define OSC_SEL_HI 7
`define OSC_SEL_LO 3
`define OSC_AUTO 2
`define OSC_ADC_EN 1
`define OSC_ADC_LATCH 0
`define ST1_DONE 7
`define ST1_SUCCESS 6
`define ST1_ACTIVE 5

// Reset values
`define RST_BYTE 8'h00
`define RST_OSC_REG 8'h00
`define RST_IDX 5'h00
`define RST_CODE 3'h0

// Bus constants
`define DEV_ADDR_BASE 7'h60
`define DEV_ADDR_MASK 7'h7E
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8
`define BIT_ZERO 4'h0
`define BIT_ONE 4'h1
`define PTR_STEP 8'h01
`define RIDX_STEP 3'h1

// Oscillator search
`define OSC_COUNT 5'h18
`define OSC_LAST 5'h17
`define IDX_STEP 5'h01
`define CODE_SRCH_LO 3'h2
`define CODE_SRCH_HI 3'h5
`define SETTLE_NS 10000
`define CLK_PERIOD_NS 10
`define SETTLE_W 10

`endif

// *** osc_search.v ***
`timescale 1ns/10ps
`include "synth_ctrl_map.vh"

module osc_search (
  input wire core_clk,
  input wire arst_n,
  input wire run_en,
  input wire start,
  input wire [4:0] start_index,
  input wire [2:0] tune_code,
  output reg busy,
  output reg done,
  output reg success,
  output reg [4:0] index
);

  // Settle time before each tune code is judged, rounded down
  localparam integer SETTLE_FULL = `SETTLE_NS / `CLK_PERIOD_NS - 1;
  localparam [`SETTLE_W-1:0] SETTLE_CYC = SETTLE_FULL[`SETTLE_W-1:0];

  // Only the band end codes CODE_SRCH_LO and CODE_SRCH_HI are taken; codes between them are not
  function in_search_band;
    input [2:0] c;
    begin
      in_search_band = (c == `CODE_SRCH_LO) || (c == `CODE_SRCH_HI);
    end
  endfunction

  reg [`SETTLE_W-1:0] settle;
  reg [4:0] tries;

  // ****************************************
  // Search sequencer
  // ****************************************
  // A retrigger restarts cleanly from the manual index
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      success <= 1'b0;
      index <= `RST_IDX;
      settle <= {`SETTLE_W{1'b0}};
      tries <= `RST_IDX;
    end else if (run_en) begin
      if (start) begin
        busy <= 1'b1;
        done <= 1'b0;
        success <= 1'b0;
        index <= start_index;
        settle <= SETTLE_CYC;
        tries <= `RST_IDX;
      end else if (busy) begin
        if (settle != {`SETTLE_W{1'b0}}) begin
          settle <= settle - 1'b1;
        end else if (in_search_band(tune_code)) begin
          busy <= 1'b0;
          done <= 1'b1;
          success <= 1'b1;
        end else if (tries == `OSC_LAST) begin
          busy <= 1'b0;
          done <= 1'b1;
          success <= 1'b0;
        end else begin
          tries <= tries + `IDX_STEP;
          index <= (index == `OSC_LAST) ? `RST_IDX : index + `IDX_STEP;
          settle <= SETTLE_CYC;
        end
      end
    end
  end

endmodule

// *** synth_ctrl_assertions.sv ***
`timescale 1ns/10ps
module synth_ctrl_checker (
  input wire core_clk,
  input wire arst_n,
  input wire scl_in,
  input wire sda_oe_n,
  input wire [14:0] integer_divide,
  input wire [19:0] fraction_word,
  input wire [4:0] reference_ratio,
  input wire [7:0] pump_and_divide,
  input wire [4:0] oscillator_in_use,
  input wire standby_request,
  input wire search_running
);
  // ****
  // Helpers
  // ****
  logic [9:0] dwell;
  logic [14:0] run_len;
  logic [4:0] last_idx;
  logic moved;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  assign moved = search_running && run_len > 15'h0008 && oscillator_in_use != last_idx;
  // Dwell saturates; run length restarts on every ACK the device drives so a retrigger never trips it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dwell <= 10'h000;
      run_len <= 15'h0000;
      last_idx <= 5'h00;
    end else begin
      last_idx <= oscillator_in_use;
      dwell <= (oscillator_in_use != last_idx) ? 10'h000 : dwell + {9'h000, dwell != 10'h3FF};
      run_len <= (search_running && sda_oe_n) ? run_len + 15'h0001 : 15'h0000;
    end
  end
  // ****
  // Properties
  // ****
  property p_div_write;
    $changed(integer_divide) || $changed(fraction_word) |-> !$past(sda_oe_n, 2);
  endproperty
  a_div_write: assert property (p_div_write) else $error("divider moved without write");
  property p_cfg_keep;
    $changed(reference_ratio) || $changed(pump_and_divide) |-> !$past(sda_oe_n, 2);
  endproperty
  a_cfg_keep: assert property (p_cfg_keep) else $error("config moved without write");
  property p_standby_request_write;
    $changed(standby_request) |-> !$past(sda_oe_n, 2);
  endproperty
  a_standby_request_write: assert property (p_standby_request_write) else $error("standby moved without write");
  property p_kick;
    $rose(search_running) |-> !$past(sda_oe_n, 3);
  endproperty
  a_kick: assert property (p_kick) else $error("search began without write");
  property p_range;
    search_running |-> oscillator_in_use < 5'h18;
  endproperty
  a_range: assert property (p_range) else $error("search index beyond last");
  property p_step;
    moved |-> oscillator_in_use == ((last_idx == 5'h17) ? 5'h00 : last_idx + 5'h01);
  endproperty
  a_step: assert property (p_step) else $error("search index skipped");
  property p_dwell;
    moved |-> dwell >= 10'h3E3;
  endproperty
  a_dwell: assert property (p_dwell) else $error("candidate left too early");
  property p_len;
    search_running |-> run_len < 15'h5E24;
  endproperty
  a_len: assert property (p_len) else $error("search ran too long");
  property p_sda;
    $changed(sda_oe_n) |-> !scl_in && !$past(scl_in);
  endproperty
  a_sda: assert property (p_sda) else $error("data moved while clock high");
endmodule

// *** synth_host_model.sv ***
`timescale 1ns/10ps
module synth_host_model (
  input wire core_clk,
  input wire sda_wire,
  output logic scl,
  output logic sda_low
);
  // ****
  // Bus phases
  // ****
  // Idle bus with both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Half bit of the 125 ns link clock; long enough for the device's two-stage synchroniser
  task automatic half();
    #62.5;
  endtask
  // Start, also a repeated start; an eighth of a cycle off the core clock so no pin moves on its edge
  task automatic start_c();
    @(negedge core_clk);
    #1.25;
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
  endtask
  // Stop: data rises while the clock is high
  task automatic stop_c();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask
  // Eight bits MSB first plus the ninth; data held through each high phase
  task automatic xfer_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
    logic [8:0] sh;
    logic [8:0] got;
    sh = {tx, ack_in};
    for (int i = 8; i >= 0; i--) begin
      sda_low = !sh[i];
      half();
      scl = 1'b1;
      half();
      got[i] = sda_wire;
      scl = 1'b0;
    end
    rx = got[8:1];
    ack_out = got[0];
  endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  logic core_clk;
  logic arst_n;
  logic addr_select;
  logic [2:0] oscillator_tune_pin;
  logic [4:0] target;
  logic [2:0] tgt_code;
  logic [7:0] rx;
  logic [7:0] st1;
  logic [7:0] st2;
  logic ack;
  wire scl;
  wire sda_low;
  wire sda_wire;
  wire sda_out;
  wire sda_oe_n;
  wire [14:0] integer_divide;
  wire [19:0] fraction_word;
  wire [4:0] reference_ratio;
  wire [7:0] pump_and_divide;
  wire [4:0] oscillator_in_use;
  wire standby_request;
  wire search_running;
  int miscompares;
  int n_checks;
  logic [4:0] start_tab [3] = '{5'h05, 5'h16, 5'h00};
  logic [4:0] tgt_tab [3] = '{5'h07, 5'h01, 5'h1F};
  logic [2:0] code_tab [3] = '{3'h5, 3'h2, 3'h0};
  // Pull-up wins unless a party pulls low
  assign sda_wire = !sda_low && (sda_oe_n || sda_out);
  synth_host_model host (.core_clk(core_clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));
  synth_vco_autoselect_ctrl dut (.core_clk(core_clk), .arst_n(arst_n), .clk_en(1'b1), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_select(addr_select),
    .oscillator_tune_pin(oscillator_tune_pin), .integer_divide(integer_divide), .fraction_word(fraction_word),
    .reference_ratio(reference_ratio), .pump_and_divide(pump_and_divide), .oscillator_in_use(oscillator_in_use),
    .standby_request(standby_request), .search_running(search_running));
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Only the target oscillator reads inside the narrow band; others read locked or unlocked
  always @(negedge core_clk) begin
    oscillator_tune_pin <= (oscillator_in_use == target) ? tgt_code : {oscillator_in_use[1], oscillator_in_use[1:0]};
  end
  // ****
  // Tasks
  // ****
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic put(input logic [7:0] b);
    host.xfer_byte(b, 1'b1, rx, ack);
    check("ack", 20'(ack), 20'h00000);
  endtask
  task automatic wr1(input logic [7:0] ptr, input logic [7:0] b);
    host.start_c();
    put(8'hC0);
    put(ptr);
    put(b);
    host.stop_c();
  endtask
  // Status read: ACK after the first byte, NACK after the second
  task automatic rd_status();
    host.start_c();
    put(8'hC1);
    host.xfer_byte(8'hFF, 1'b0, st1, ack);
    host.xfer_byte(8'hFF, 1'b1, st2, ack);
    host.stop_c();
  endtask
  task automatic wait_idle(input int bound);
    int n;
    n = 0;
    while (search_running !== 1'b0 && n < bound) begin
      @(negedge core_clk);
      n++;
    end
    if (search_running !== 1'b0) begin
      miscompares++;
      stop_test();
    end
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    arst_n = 1'b0;
    addr_select = 1'b0;
    oscillator_tune_pin = 3'h0;
    target = 5'h1F;
    tgt_code = 3'h0;
    miscompares = 0;
    n_checks = 0;
    repeat (3) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (6) @(negedge core_clk);
    host.start_c();
    host.xfer_byte(8'hC2, 1'b1, rx, ack);
    host.stop_c();
    check("foreign addr", 20'(ack), 20'h00001);
    addr_select = 1'b1;
    repeat (6) @(negedge core_clk);
    host.start_c();
    host.xfer_byte(8'hC2, 1'b1, rx, ack);
    host.stop_c();
    check("pin addr", 20'(ack), 20'h00000);
    addr_select = 1'b0;
    repeat (10000) @(negedge core_clk);
    host.start_c();
    put(8'hC0);
    put(8'h06);
    put(8'h01);
    put(8'h5A);
    put(8'h11);
    host.stop_c();
    host.start_c();
    put(8'hC0);
    put(8'h01);
    put(8'h00);
    put(8'h50);
    put(8'h05);
    put(8'hED);
    put(8'h09);
    host.stop_c();
    check("integer", 20'(integer_divide), 20'h00050);
    check("fraction", fraction_word, 20'h5ED09);
    check("reference", 20'(reference_ratio), 20'h00001);
    check("pump", 20'(pump_and_divide), 20'h0005A);
    check("manual osc", 20'(oscillator_in_use), 20'h00002);
    rd_status();
    check("unlatched", 20'(st2), 20'h00010);
    wr1(8'h08, 8'h12);
    wr1(8'h08, 8'h13);
    rd_status();
    check("latched", 20'(st2), 20'h00016);
    wr1(8'h00, 8'h80);
    check("standby", 20'(standby_request), 20'h00001);
    wr1(8'h09, 8'h77);
    wr1(8'h00, 8'h00);
    check("awake", 20'(standby_request), 20'h00000);
    check("kept fraction", fraction_word, 20'h5ED09);
    check("kept integer", 20'(integer_divide), 20'h00050);
    for (int k = 0; k < 3; k++) begin
      target = tgt_tab[k];
      tgt_code = code_tab[k];
      wr1(8'h08, {start_tab[k], 3'h6});
      repeat (2) wr1(8'h05, 8'h09);
      check("running", 20'(search_running), 20'h00001);
      rd_status();
      check("done low", 20'(st1[7]), 20'h00000);
      wait_idle(k < 2 ? 5000 : 26000);
      rd_status();
      check("end flags", 20'(st1[7:6]), (k < 2) ? 20'h00003 : 20'h00002);
      if (k < 2) begin
        check("chosen", 20'(st2[7:3]), 20'(tgt_tab[k]));
      end
    end
    stop_test();
  end
endmodule
bind synth_vco_autoselect_ctrl synth_ctrl_checker chk (.core_clk(core_clk), .arst_n(arst_n), .scl_in(scl_in),
  .sda_oe_n(sda_oe_n), .integer_divide(integer_divide), .fraction_word(fraction_word),
  .reference_ratio(reference_ratio), .pump_and_divide(pump_and_divide), .oscillator_in_use(oscillator_in_use),
  .standby_request(standby_request), .search_running(search_running));
